// >>> wocfg_defs.vh
`ifndef WOCFG_DEFS_VH
`define WOCFG_DEFS_VH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define WOCFG_ADDR_W        16
`define WOCFG_CFG_TWO_ADDR  16'h001d
`define WOCFG_CFG_ONE_ADDR  16'h001f
`define WOCFG_CFG_RESET     8'h00

// -----------------------------------------------------------------------------
// Field positions of system_config_one
// -----------------------------------------------------------------------------
`define WOCFG_C1_WDG_RATE   7
`define WOCFG_C1_MON_STOP   6
`define WOCFG_C1_MON_RSTD   5
`define WOCFG_C1_MAIN_MOND  4
`define WOCFG_C1_REG_MOND   3
`define WOCFG_C1_SHORT_REC  2
`define WOCFG_C1_STOP_EN    1
`define WOCFG_C1_WDG_DIS    0

// -----------------------------------------------------------------------------
// Field positions of system_config_two
// -----------------------------------------------------------------------------
`define WOCFG_C2_INTERNAL_OSC_CLOCK_DIS   7
`define WOCFG_C2_RC_EN      6
`define WOCFG_C2_XTAL_EN    5
`define WOCFG_C2_TB_HI      4
`define WOCFG_C2_TB_LO      3
`define WOCFG_C2_SER_SRC    0

// -----------------------------------------------------------------------------
// Timing counts in internal oscillator cycles
// -----------------------------------------------------------------------------
`define WOCFG_WDG_SHORT     19'd8176
`define WOCFG_WDG_LONG      19'd262128
`define WOCFG_REC_SHORT     13'd32
`define WOCFG_REC_LONG      13'd4096

// -----------------------------------------------------------------------------
// Timebase clock select codes
// -----------------------------------------------------------------------------
`define WOCFG_TB_INTERNAL   2'b00
`define WOCFG_TB_RC         2'b01
`define WOCFG_TB_CRYSTAL    2'b10

`endif

// >>> wocfg_once_reg.v
`timescale 1ns/1ps
`default_nettype none
`include "wocfg_defs.vh"

// One write-once byte register with its own arming latch.
module wocfg_once_reg #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             wr_en,
  input  wire [WIDTH-1:0] wr_data,
  output reg  [WIDTH-1:0] value_reg,
  output reg              written_reg
);

  // Reset clears the value and re-arms; only the first write is stored.
  always @(posedge clk) begin
    if (!rst_n) begin
      value_reg   <= {WIDTH{1'b0}};
      written_reg <= 1'b0;
    end else if (wr_en && !written_reg) begin
      value_reg   <= wr_data;
      written_reg <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// >>> wocfg_top.v
`timescale 1ns/1ps
`default_nettype none
`include "wocfg_defs.vh"

// Summary of operation
// - Each configuration register stores only its first write after reset.
// - Reset clears both registers to zero and re-arms their single write.
// - Both registers read back their current contents at any time.
// - Watchdog rate bit picks 2^13-2^4 or 2^18-2^4 oscillator cycles.
// - Watchdog disable bit switches the watchdog off when set.
// - Monitor reset disable bit blocks monitor-issued resets when set.
// - Main supply monitor disable bit switches that detector off.
// - Regulator monitor disable bit switches that detector off.
// - Short recovery bit picks 32 or 4096 oscillator cycles stop exit.
// - Stop exit by external reset always uses the long delay.
// - With stop enable clear the stop opcode is illegal.
// - Internal oscillator stop disable halts it in stop mode when set.
// - RC oscillator stop enable keeps it running in stop when set.
// - Crystal oscillator stop enable keeps it running in stop when set.
// - Two-bit timebase select routes internal, RC or crystal clock.
// - Serial clock source bit picks bus clock or oscillator output clock.
module wocfg_top (
  input  wire                      clk,
  input  wire                      rst_n,
  input  wire [`WOCFG_ADDR_W-1:0]  addr,
  input  wire [7:0]                wdata,
  input  wire                      wr_stb,
  input  wire                      rd_stb,
  input  wire                      stop_mode,
  input  wire                      stop_opcode,
  input  wire                      ext_reset_wake,
  input  wire                      internal_osc_clock,
  input  wire                      rc_osc_clock,
  input  wire                      crystal_osc_clock,
  input  wire                      bus_clock,
  input  wire                      oscillator_output_clock,
  input  wire                      main_supply_low,
  input  wire                      regulator_low,
  output reg  [7:0]                rdata_reg,
  output reg  [18:0]               watchdog_timeout_reg,
  output reg                       watchdog_enable_reg,
  output reg                       main_monitor_on_reg,
  output reg                       regulator_monitor_on_reg,
  output reg                       monitor_reset_reg,
  output reg  [12:0]               stop_recovery_cycles_reg,
  output reg                       illegal_opcode_reg,
  output reg                       internal_osc_run_reg,
  output reg                       rc_osc_run_reg,
  output reg                       crystal_osc_run_reg,
  output reg                       timebase_clock_reg,
  output reg                       serial_clock_reg,
  output reg  [1:0]                written_flags_reg
);

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  wire [7:0] cfg_one;
  wire [7:0] cfg_two;
  wire       one_written;
  wire       two_written;
  wire       hit_one;
  wire       hit_two;

  assign hit_one = (addr == `WOCFG_CFG_ONE_ADDR);
  assign hit_two = (addr == `WOCFG_CFG_TWO_ADDR);

  // First-write capture; later writes are ignored inside the cell.
  wocfg_once_reg #(.WIDTH(8)) u_cfg_one (
    .clk         (clk),
    .rst_n       (rst_n),
    .wr_en       (wr_stb && hit_one),
    .wr_data     (wdata),
    .value_reg   (cfg_one),
    .written_reg (one_written)
  );

  wocfg_once_reg #(.WIDTH(8)) u_cfg_two (
    .clk         (clk),
    .rst_n       (rst_n),
    .wr_en       (wr_stb && hit_two),
    .wr_data     (wdata),
    .value_reg   (cfg_two),
    .written_reg (two_written)
  );

  // ---------------------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------------------
  wire       watchdog_rate_select;
  wire       monitor_in_stop_enable;
  wire       monitor_reset_disable;
  wire       main_supply_monitor_disable;
  wire       regulator_monitor_disable;
  wire       short_recovery_select;
  wire       stop_enable;
  wire       watchdog_disable;
  wire       internal_osc_stop_disable;
  wire       rc_osc_stop_enable;
  wire       crystal_osc_stop_enable;
  wire [1:0] timebase_select;
  wire       serial_clock_source_select;

  assign watchdog_rate_select        = cfg_one[`WOCFG_C1_WDG_RATE];
  assign monitor_in_stop_enable      = cfg_one[`WOCFG_C1_MON_STOP];
  assign monitor_reset_disable       = cfg_one[`WOCFG_C1_MON_RSTD];
  assign main_supply_monitor_disable = cfg_one[`WOCFG_C1_MAIN_MOND];
  assign regulator_monitor_disable   = cfg_one[`WOCFG_C1_REG_MOND];
  assign short_recovery_select       = cfg_one[`WOCFG_C1_SHORT_REC];
  assign stop_enable                 = cfg_one[`WOCFG_C1_STOP_EN];
  assign watchdog_disable            = cfg_one[`WOCFG_C1_WDG_DIS];
  assign internal_osc_stop_disable   = cfg_two[`WOCFG_C2_INTERNAL_OSC_CLOCK_DIS];
  assign rc_osc_stop_enable          = cfg_two[`WOCFG_C2_RC_EN];
  assign crystal_osc_stop_enable     = cfg_two[`WOCFG_C2_XTAL_EN];
  assign timebase_select             = {cfg_two[`WOCFG_C2_TB_HI], cfg_two[`WOCFG_C2_TB_LO]};
  assign serial_clock_source_select  = cfg_two[`WOCFG_C2_SER_SRC];

  // Detectors run when not disabled and, in stop, only if monitoring in stop is on.
  wire main_on;
  wire reg_on;
  assign main_on = !main_supply_monitor_disable && (!stop_mode || monitor_in_stop_enable);
  assign reg_on  = !regulator_monitor_disable && (!stop_mode || monitor_in_stop_enable);

  // Timebase clock mux; the unused code gives a quiet low clock.
  reg tb_clk_next;
  always @* begin
    case (timebase_select)
      `WOCFG_TB_INTERNAL: tb_clk_next = internal_osc_clock;
      `WOCFG_TB_RC:       tb_clk_next = rc_osc_clock;
      `WOCFG_TB_CRYSTAL:  tb_clk_next = crystal_osc_clock;
      default:            tb_clk_next = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------------------
  // Data stand in the cycle after the read strobe only; unmapped reads give zero.
  always @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= `WOCFG_CFG_RESET;
    end else if (rd_stb && hit_one) begin
      rdata_reg <= cfg_one;
    end else if (rd_stb && hit_two) begin
      rdata_reg <= cfg_two;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Registered control outputs
  // ---------------------------------------------------------------------------
  // Next values, one wire per output flop below except the detector enables and timebase clock, so each flop stays trivial.
  wire [18:0] watchdog_timeout_next;
  wire        watchdog_enable_next;
  wire        monitor_reset_next;
  wire [12:0] stop_recovery_cycles_next;
  wire        illegal_opcode_next;
  wire        internal_osc_run_next;
  wire        rc_osc_run_next;
  wire        crystal_osc_run_next;
  wire        serial_clock_next;
  wire [1:0]  written_flags_next;

  // Watchdog length and on/off come straight from the first register.
  assign watchdog_timeout_next = watchdog_rate_select ? `WOCFG_WDG_SHORT : `WOCFG_WDG_LONG;
  assign watchdog_enable_next  = !watchdog_disable;

  // A low supply seen by a running detector resets unless blocked.
  assign monitor_reset_next = !monitor_reset_disable &&
                              ((main_on && main_supply_low) || (reg_on && regulator_low));

  // Stop exit delay; a wake by external reset always takes the long delay.
  assign stop_recovery_cycles_next = (short_recovery_select && !ext_reset_wake) ?
                                     `WOCFG_REC_SHORT : `WOCFG_REC_LONG;

  // The stop opcode is refused while the stop instruction is not enabled.
  assign illegal_opcode_next = stop_opcode && !stop_enable;

  // Oscillator run enables; outside stop mode every oscillator runs.
  assign internal_osc_run_next = !(stop_mode && internal_osc_stop_disable);
  assign rc_osc_run_next       = !stop_mode || rc_osc_stop_enable;
  assign crystal_osc_run_next  = !stop_mode || crystal_osc_stop_enable;

  // Serial source clock and the written marks of both registers.
  assign serial_clock_next  = serial_clock_source_select ? bus_clock : oscillator_output_clock;
  assign written_flags_next = {two_written, one_written};

  // ---------------------------------------------------------------------------
  // Output flops
  // ---------------------------------------------------------------------------
  // Watchdog length; reset leaves the long timeout selected.
  always @(posedge clk) begin
    if (!rst_n) begin
      watchdog_timeout_reg <= `WOCFG_WDG_LONG;
    end else begin
      watchdog_timeout_reg <= watchdog_timeout_next;
    end
  end

  // Watchdog run enable; the watchdog runs out of reset.
  always @(posedge clk) begin
    if (!rst_n) begin
      watchdog_enable_reg <= 1'b1;
    end else begin
      watchdog_enable_reg <= watchdog_enable_next;
    end
  end

  // Main supply detector run enable.
  always @(posedge clk) begin
    if (!rst_n) begin
      main_monitor_on_reg <= 1'b1;
    end else begin
      main_monitor_on_reg <= main_on;
    end
  end

  // Regulator detector run enable.
  always @(posedge clk) begin
    if (!rst_n) begin
      regulator_monitor_on_reg <= 1'b1;
    end else begin
      regulator_monitor_on_reg <= reg_on;
    end
  end

  // Monitor reset request; never raised while reset is applied.
  always @(posedge clk) begin
    if (!rst_n) begin
      monitor_reset_reg <= 1'b0;
    end else begin
      monitor_reset_reg <= monitor_reset_next;
    end
  end

  // Stop recovery length in internal oscillator cycles.
  always @(posedge clk) begin
    if (!rst_n) begin
      stop_recovery_cycles_reg <= `WOCFG_REC_LONG;
    end else begin
      stop_recovery_cycles_reg <= stop_recovery_cycles_next;
    end
  end

  // Illegal opcode flag for a refused stop instruction.
  always @(posedge clk) begin
    if (!rst_n) begin
      illegal_opcode_reg <= 1'b0;
    end else begin
      illegal_opcode_reg <= illegal_opcode_next;
    end
  end

  // Internal oscillator run enable.
  always @(posedge clk) begin
    if (!rst_n) begin
      internal_osc_run_reg <= 1'b1;
    end else begin
      internal_osc_run_reg <= internal_osc_run_next;
    end
  end

  // RC oscillator run enable.
  always @(posedge clk) begin
    if (!rst_n) begin
      rc_osc_run_reg <= 1'b1;
    end else begin
      rc_osc_run_reg <= rc_osc_run_next;
    end
  end

  // Crystal oscillator run enable.
  always @(posedge clk) begin
    if (!rst_n) begin
      crystal_osc_run_reg <= 1'b1;
    end else begin
      crystal_osc_run_reg <= crystal_osc_run_next;
    end
  end

  // Selected timebase clock, one cycle behind its source.
  always @(posedge clk) begin
    if (!rst_n) begin
      timebase_clock_reg <= 1'b0;
    end else begin
      timebase_clock_reg <= tb_clk_next;
    end
  end

  // Selected serial clock, one cycle behind its source.
  always @(posedge clk) begin
    if (!rst_n) begin
      serial_clock_reg <= 1'b0;
    end else begin
      serial_clock_reg <= serial_clock_next;
    end
  end

  // Written marks, one cycle behind the arming latches.
  always @(posedge clk) begin
    if (!rst_n) begin
      written_flags_reg <= 2'b00;
    end else begin
      written_flags_reg <= written_flags_next;
    end
  end

endmodule

`default_nettype wire

// >>> wocfg_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "wocfg_defs.vh"
// ---------------------------------------------------------------
// Port checker for the write-once configuration block.
// ---------------------------------------------------------------
module wocfg_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic        stop_mode,
  input wire logic        stop_opcode,
  input wire logic        ext_reset_wake,
  input wire logic        main_supply_low,
  input wire logic        regulator_low,
  input wire logic [7:0]  rdata_reg,
  input wire logic [18:0] watchdog_timeout_reg,
  input wire logic        watchdog_enable_reg,
  input wire logic        main_monitor_on_reg,
  input wire logic        regulator_monitor_on_reg,
  input wire logic        monitor_reset_reg,
  input wire logic [12:0] stop_recovery_cycles_reg,
  input wire logic        illegal_opcode_reg,
  input wire logic        internal_osc_run_reg,
  input wire logic        rc_osc_run_reg,
  input wire logic        crystal_osc_run_reg,
  input wire logic [1:0]  written_flags_reg
);
  logic [7:0] one_reg;
  logic [7:0] two_reg;
  logic [1:0] armed_reg;
  // Shadow copies keep only the first write after reset.
  always @(posedge clk) begin
    if (!rst_n)
      {armed_reg, two_reg, one_reg} <= 18'h00000;
    else if (wr_stb && !armed_reg[0] && addr == `WOCFG_CFG_ONE_ADDR)
      {armed_reg[0], one_reg} <= {1'b1, wdata};
    else if (wr_stb && !armed_reg[1] && addr == `WOCFG_CFG_TWO_ADDR)
      {armed_reg[1], two_reg} <= {1'b1, wdata};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd_one; rd_stb && addr == `WOCFG_CFG_ONE_ADDR; endsequence
  sequence s_rd_two; rd_stb && addr == `WOCFG_CFG_TWO_ADDR; endsequence
  property p_flags; written_flags_reg == $past(armed_reg); endproperty
  a_flags: assert property (p_flags) else $error("written flags wrong");
  property p_rd_one; s_rd_one |=> rdata_reg == one_reg; endproperty
  a_rd_one: assert property (p_rd_one) else $error("first register readback wrong");
  property p_rd_two; s_rd_two |=> rdata_reg == two_reg; endproperty
  a_rd_two: assert property (p_rd_two) else $error("second register readback wrong");
  property p_rd_idle; !rd_stb |=> rdata_reg == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
  property p_wdg;
    watchdog_timeout_reg == ($past(one_reg[7]) ? `WOCFG_WDG_SHORT : `WOCFG_WDG_LONG)
      && watchdog_enable_reg == !$past(one_reg[0]);
  endproperty
  a_wdg: assert property (p_wdg) else $error("watchdog setting wrong");
  property p_rec;
    stop_recovery_cycles_reg == (($past(one_reg[2]) && !$past(ext_reset_wake)) ? 13'd32 : 13'd4096);
  endproperty
  a_rec: assert property (p_rec) else $error("recovery delay wrong");
  property p_illegal; illegal_opcode_reg == ($past(stop_opcode) && !$past(one_reg[1])); endproperty
  a_illegal: assert property (p_illegal) else $error("illegal opcode flag wrong");
  property p_osc;
    internal_osc_run_reg == !($past(stop_mode) && $past(two_reg[7]))
      && rc_osc_run_reg == (!$past(stop_mode) || $past(two_reg[6]))
      && crystal_osc_run_reg == (!$past(stop_mode) || $past(two_reg[5]));
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator run enable wrong");
  property p_mon;
    main_monitor_on_reg == (!$past(one_reg[4]) && (!$past(stop_mode) || $past(one_reg[6])))
      && regulator_monitor_on_reg == (!$past(one_reg[3]) && (!$past(stop_mode) || $past(one_reg[6])));
  endproperty
  a_mon: assert property (p_mon) else $error("monitor enable wrong");
  property p_mon_rst;
    monitor_reset_reg == (!$past(one_reg[5])
      && ((main_monitor_on_reg && $past(main_supply_low)) || (regulator_monitor_on_reg && $past(regulator_low))));
  endproperty
  a_mon_rst: assert property (p_mon_rst) else $error("monitor reset request wrong");
endmodule

bind wocfg_top wocfg_asserts i_chk (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .stop_mode(stop_mode), .stop_opcode(stop_opcode), .ext_reset_wake(ext_reset_wake),
  .main_supply_low(main_supply_low), .regulator_low(regulator_low),
  .rdata_reg(rdata_reg), .watchdog_timeout_reg(watchdog_timeout_reg), .watchdog_enable_reg(watchdog_enable_reg),
  .main_monitor_on_reg(main_monitor_on_reg), .regulator_monitor_on_reg(regulator_monitor_on_reg),
  .monitor_reset_reg(monitor_reset_reg), .stop_recovery_cycles_reg(stop_recovery_cycles_reg),
  .illegal_opcode_reg(illegal_opcode_reg), .internal_osc_run_reg(internal_osc_run_reg),
  .rc_osc_run_reg(rc_osc_run_reg), .crystal_osc_run_reg(crystal_osc_run_reg),
  .written_flags_reg(written_flags_reg)
);
`default_nettype wire

// >>> wocfg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "wocfg_defs.vh"
// ---------------------------------------------------------------
// Self-checking bench for the write-once configuration block.
// ---------------------------------------------------------------
module wocfg_top_tb;
  logic        clk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, stop_mode = 1'b0;
  logic        stop_opcode = 1'b0, ext_reset_wake = 1'b0, internal_osc_clock = 1'b0, rc_osc_clock = 1'b0;
  logic        crystal_osc_clock = 1'b0, bus_clock = 1'b0, oscillator_output_clock = 1'b0;
  logic        main_supply_low = 1'b0, regulator_low = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  wire  [7:0]  rdata_reg;
  wire  [18:0] watchdog_timeout_reg;
  wire  [12:0] stop_recovery_cycles_reg;
  wire  [1:0]  written_flags_reg;
  wire         watchdog_enable_reg, main_monitor_on_reg, regulator_monitor_on_reg, monitor_reset_reg;
  wire         illegal_opcode_reg, internal_osc_run_reg, rc_osc_run_reg, crystal_osc_run_reg;
  wire         timebase_clock_reg, serial_clock_reg;
  int          errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  localparam logic [15:0] A1 = `WOCFG_CFG_ONE_ADDR;
  localparam logic [15:0] A2 = `WOCFG_CFG_TWO_ADDR;

  wocfg_top i_dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .stop_mode(stop_mode), .stop_opcode(stop_opcode), .ext_reset_wake(ext_reset_wake),
    .internal_osc_clock(internal_osc_clock), .rc_osc_clock(rc_osc_clock), .crystal_osc_clock(crystal_osc_clock),
    .bus_clock(bus_clock), .oscillator_output_clock(oscillator_output_clock),
    .main_supply_low(main_supply_low), .regulator_low(regulator_low),
    .rdata_reg(rdata_reg), .watchdog_timeout_reg(watchdog_timeout_reg), .watchdog_enable_reg(watchdog_enable_reg),
    .main_monitor_on_reg(main_monitor_on_reg), .regulator_monitor_on_reg(regulator_monitor_on_reg),
    .monitor_reset_reg(monitor_reset_reg), .stop_recovery_cycles_reg(stop_recovery_cycles_reg),
    .illegal_opcode_reg(illegal_opcode_reg), .internal_osc_run_reg(internal_osc_run_reg),
    .rc_osc_run_reg(rc_osc_run_reg), .crystal_osc_run_reg(crystal_osc_run_reg),
    .timebase_clock_reg(timebase_clock_reg), .serial_clock_reg(serial_clock_reg),
    .written_flags_reg(written_flags_reg)
  );

  // Clock and hang guard.
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      end_of_test();
    end
  end

  // Verdict and run end.
  task automatic end_of_test();
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus cycle, driven just after an edge.
  task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    wr_stb <= w;
    rd_stb <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic step();
    bus(1'b0, 1'b0, 16'h0000, 8'h00);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, 8'h00);
    #1;
    chk({11'h000, rdata_reg}, {11'h000, e});
  endtask
  // Eight-cycle reset, then the cleared state is checked.
  task automatic do_reset();
    rst_n <= 1'b0;
    {wr_stb, rd_stb} <= 2'b00;
    {stop_mode, stop_opcode, ext_reset_wake, main_supply_low, regulator_low} <= 5'b00000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({written_flags_reg, watchdog_enable_reg, stop_recovery_cycles_reg}, {2'b00, 1'b1, 13'h1000});
    chk(watchdog_timeout_reg, `WOCFG_WDG_LONG);
  endtask

  // Repeated writes, unmapped access and stop-related outputs.
  task automatic t_first();
    do_reset();
    rd(A1, 8'h00);
    rd(16'h001e, 8'h00);
    // Reset requests are blocked before stop, and a wake by external reset in stop overrides short recovery with the long delay.
    bus(1'b1, 1'b0, A1, 8'ha5);
    bus(1'b1, 1'b0, A1, 8'h7a);
    bus(1'b1, 1'b0, A2, 8'h00);
    bus(1'b1, 1'b0, A2, 8'hff);
    bus(1'b1, 1'b0, 16'h001e, 8'hff);
    step();
    step();
    rd(A1, 8'ha5);
    rd(A2, 8'h00);
    chk({watchdog_enable_reg, stop_recovery_cycles_reg, written_flags_reg}, {1'b0, 13'h0020, 2'b11});
    chk(watchdog_timeout_reg, `WOCFG_WDG_SHORT);
    main_supply_low <= 1'b1;
    step();
    chk(monitor_reset_reg, 19'h0);
    {stop_mode, stop_opcode, ext_reset_wake} <= 3'b111;
    step();
    chk({stop_recovery_cycles_reg, illegal_opcode_reg}, {13'h1000, 1'b1});
    chk({internal_osc_run_reg, rc_osc_run_reg, crystal_osc_run_reg}, 19'h4);
    chk({main_monitor_on_reg, regulator_monitor_on_reg}, 19'h0);
  endtask
  // A second reset re-arms the writes; monitors and oscillators in stop.
  task automatic t_second();
    do_reset();
    rd(A1, 8'h00);
    bus(1'b1, 1'b0, A1, 8'h52);
    bus(1'b1, 1'b0, A2, 8'he0);
    bus(1'b1, 1'b0, A1, 8'h00);
    step();
    {stop_mode, stop_opcode, regulator_low} <= 3'b111;
    step();
    chk({main_monitor_on_reg, regulator_monitor_on_reg, illegal_opcode_reg, monitor_reset_reg}, 19'h5);
    chk({internal_osc_run_reg, rc_osc_run_reg, crystal_osc_run_reg}, 19'h3);
    rd(A1, 8'h52);
  endtask
  // Every timebase select code and both serial sources.
  task automatic t_select();
    for (int k = 0; k < 4; k++) begin
      do_reset();
      bus(1'b1, 1'b0, A1, 8'h38);
      bus(1'b1, 1'b0, A2, {3'b000, k[1:0], 2'b00, k[0]});
      step();
      {crystal_osc_clock, rc_osc_clock, internal_osc_clock} <= 3'b001 << k;
      {bus_clock, oscillator_output_clock} <= 2'b10;
      step();
      step();
      chk({timebase_clock_reg, serial_clock_reg}, {17'h0, k < 3, k[0]});
      chk({main_monitor_on_reg, regulator_monitor_on_reg, monitor_reset_reg}, 19'h0);
      {crystal_osc_clock, rc_osc_clock, internal_osc_clock} <= ~(3'b001 << k);
      {bus_clock, oscillator_output_clock} <= 2'b01;
      step();
      step();
      chk({timebase_clock_reg, serial_clock_reg}, {17'h0, 1'b0, !k[0]});
    end
  endtask

  // Main sequence.
  initial begin
    t_first();
    t_second();
    t_select();
    end_of_test();
  end
endmodule
`default_nettype wire
